// ==== mode_reg_pkg.sv ====
// Constants for the mode register capture and decode block
package mode_reg_pkg;
  localparam int          MR_WIDTH        = 22;
  localparam int          SEL_HI          = 20;
  localparam int          SEL_LO          = 18;
  localparam logic [2:0]  SEL_BURST_LAT   = 3'h0;
  localparam logic [2:0]  SEL_OUT_TERM    = 3'h1;
  localparam logic [2:0]  SEL_DO_NOT_USE  = 3'h7;
  localparam int          RSV_TOP_POS     = 21;
  localparam int          RSV_LOW_POS     = 17;
  localparam int          DLL_RESET_POS   = 8;
  localparam int          TEST_BIT_POS    = 7;
  localparam int          ORDER_TYPE_POS  = 3;
  localparam int          OUT_DIS_POS     = 12;
  localparam int          XTERM_POS       = 11;
  localparam int          LEVEL_POS       = 7;
  localparam logic [1:0]  SIZE_FIXED8     = 2'h0;
  localparam logic [1:0]  SIZE_PER_CMD    = 2'h1;
  localparam logic [1:0]  SIZE_FIXED4     = 2'h2;
  localparam logic [1:0]  ADD_ZERO        = 2'h0;
  localparam logic [1:0]  ADD_MINUS1      = 2'h1;
  localparam logic [1:0]  ADD_MINUS2      = 2'h2;
  localparam logic [3:0]  RECOV_MAX_CODE  = 4'h8;
  localparam logic [4:0]  CAS_MAX_CODE    = 5'h17;
  localparam logic [4:0]  CAS_STACK_A     = 5'h10;
  localparam logic [4:0]  CAS_STACK_B     = 5'h12;
  localparam int          BEATS           = 8;
  localparam int          CHOP_SHIFT      = 2;
endpackage

// ==== burst_order_gen.sv ====
// Burst beat order generator
`timescale 1ns/100ps
module burst_order_gen
  import mode_reg_pkg::*;
(
  input  wire logic [2:0]  start_col_in,
  input  wire logic        interleave_in,
  input  wire logic        is_write_in,
  input  wire logic        chop_in,
  output logic      [23:0] order_out,
  output logic      [7:0]  beat_drive_out
);
  // ----------------------------------------
  // Beat order
  // ----------------------------------------
  always_comb begin
    logic [2:0] s;
    logic [2:0] b;
    s = start_col_in;
    b = 3'h0;
    order_out = 24'h0;
    beat_drive_out = 8'h0;
    if (is_write_in) begin
      s = chop_in ? {start_col_in[2], 2'b00} : 3'h0;
    end
    for (int i = 0; i < BEATS; i++) begin
      b = 3'(i);
      if (interleave_in) begin
        order_out[i*3 +: 3] = b ^ s;
      end else begin
        order_out[i*3 +: 3] = {s[2] ^ b[2], 2'(s[1:0] + b[1:0])};
      end
      beat_drive_out[i] = !(chop_in && i >= 4);
    end
  end
endmodule

// ==== sdram_mode_reg_decode.sv ====
// Mode register capture, field decode and burst control
`timescale 1ns/100ps
// Summary of operation
// - MRS loads bits 21..17 and 13..0 from bank group, bank and address pins.
// - Select bits 20:18 route write to register 0 or 1; codes 010..110 and unused 111 change nothing.
// - Recovery code 0000..1000 gives write recovery and precharge pairs; rest reserved.
// - DLL reset bit self-clears after issuing reset; controller waits lock time.
// - Vendor test bit must be zero; one enters unspecified test mode.
// - Five-bit read delay code maps to 9..32 clocks; two codes stacked only.
// - Burst size selects fixed eight, per-command, or fixed four-beat chop.
// - Per-command mode uses burst chop pin at each column command.
// - Order type picks nibble wrap or interleaved XOR beat order.
// - Chopped read drives four beats then leaves outputs undriven.
// - Writes ignore low start column bits; chop picks lower or upper half.
// - Fixed chop starts internal write two clocks earlier.
// - Total read latency is added latency plus read delay, whole clocks.
// - With masking and checksum on, checksum mismatch aborts the write.
// - Output disable bit turns off drivers and termination.
// - Extra termination strobe enable only valid on byte-wide parts.
// - Nominal termination code selects off or calibration resistor fraction.
// - Leveling bit enters write leveling mode.
// - Added latency field selects zero, delay minus one or minus two.
// - Driver impedance field selects resistor over seven or five.
module sdram_mode_reg_decode
#(
  parameter bit BYTE_WIDE_PART = 1'b1,
  parameter bit STACKED_DIE    = 1'b0
)
(
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clk_en_in,
  input  wire logic        cs_n_in,
  input  wire logic        ras_n_in,
  input  wire logic        cas_n_in,
  input  wire logic        we_n_in,
  input  wire logic [1:0]  bank_group_in,
  input  wire logic [1:0]  bank_in,
  input  wire logic [17:0] addr_in,
  input  wire logic        dll_reset_done_in,
  input  wire logic        mask_enable_in,
  input  wire logic        crc_enable_in,
  input  wire logic        crc_ok_in,
  output logic [4:0]       write_recovery_count_out,
  output logic [3:0]       read_to_precharge_count_out,
  output logic             recovery_reserved_out,
  output logic             dll_reset_req_out,
  output logic             vendor_test_mode_out,
  output logic [5:0]       read_cas_delay_out,
  output logic             cas_code_invalid_out,
  output logic [1:0]       burst_size_out,
  output logic             burst_order_type_out,
  output logic [5:0]       added_command_latency_out,
  output logic [6:0]       total_read_latency_out,
  output logic             output_disable_out,
  output logic             extra_termination_strobe_out,
  output logic [2:0]       nominal_termination_out,
  output logic [2:0]       nominal_termination_div_out,
  output logic             write_leveling_mode_out,
  output logic             driver_impedance_out,
  output logic             driver_impedance_reserved_out,
  output logic             col_cmd_out,
  output logic             four_beat_chop_out,
  output logic [23:0]      beat_order_out,
  output logic [7:0]       beat_drive_out,
  output logic             early_write_start_out,
  output logic             write_commit_out,
  output logic             write_abort_out
);
  import mode_reg_pkg::*;

  if (BEATS != 8) $error("beat order bus is sized for eight beats");

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic                is_mrs;
  logic                is_col;
  logic                is_write;
  logic [MR_WIDTH-1:0] mrs_word;
  logic [2:0]          sel;
  logic [MR_WIDTH-1:0] burst_latency_mode_reg_r;
  logic [MR_WIDTH-1:0] output_termination_mode_reg_r;
  logic                chop_sel;
  // mode command with all four strobes low
  assign is_mrs   = !cs_n_in && !ras_n_in && !cas_n_in && !we_n_in;
  assign is_col   = !cs_n_in && ras_n_in && !cas_n_in;
  assign is_write = !we_n_in;
  assign mrs_word = {bank_group_in, bank_in, addr_in[17], 3'h0, addr_in[13:0]};
  assign sel      = mrs_word[SEL_HI:SEL_LO];

  // ----------------------------------------
  // Register capture
  // ----------------------------------------
  // contents change only on a matching mode write
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      burst_latency_mode_reg_r      <= '0;
      output_termination_mode_reg_r <= '0;
    end else if (clk_en_in && is_mrs) begin
      if (sel == SEL_BURST_LAT) begin
        burst_latency_mode_reg_r <= mrs_word;
      end
      if (sel == SEL_OUT_TERM) begin
        output_termination_mode_reg_r <= mrs_word;
      end
    end
  end
  // DLL reset request clears itself once issued
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      dll_reset_req_out <= 1'b0;
    end else if (clk_en_in) begin
      if (is_mrs && sel == SEL_BURST_LAT) begin
        dll_reset_req_out <= mrs_word[DLL_RESET_POS];
      end else if (dll_reset_done_in) begin
        dll_reset_req_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Field decode functions
  // ----------------------------------------
  function automatic logic [5:0] cas_decode(input logic [4:0] c);
    logic [5:0] v;
    case (c)
      5'h08: v = 6'd18;
      5'h09: v = 6'd20;
      5'h0A: v = 6'd22;
      5'h0B: v = 6'd24;
      5'h0C: v = 6'd23;
      5'h0D: v = 6'd17;
      5'h0E: v = 6'd19;
      5'h0F: v = 6'd21;
      default: v = 6'(6'd9 + c);
    endcase
    return v;
  endfunction
  function automatic logic [4:0] recov_decode(input logic [3:0] c);
    logic [4:0] v;
    // recovery pairs, codes 0110 and 0111 swapped
    case (c)
      4'h6:    v = 5'd24;
      4'h7:    v = 5'd22;
      4'h8:    v = 5'd26;
      default: v = 5'(5'd10 + {c, 1'b0});
    endcase
    return v;
  endfunction

  // ----------------------------------------
  // Burst and latency fields
  // ----------------------------------------
  logic [3:0] recov_code;
  logic [4:0] cas_code;
  logic [5:0] cas_val;
  logic [1:0] add_code;
  assign recov_code = {burst_latency_mode_reg_r[13], burst_latency_mode_reg_r[11:9]};
  assign cas_code   = {burst_latency_mode_reg_r[12], burst_latency_mode_reg_r[6:4],
                       burst_latency_mode_reg_r[2]};
  assign cas_val    = cas_decode(cas_code);
  assign add_code   = output_termination_mode_reg_r[4:3];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      write_recovery_count_out    <= '0;
      read_to_precharge_count_out <= '0;
      recovery_reserved_out       <= 1'b0;
      read_cas_delay_out          <= '0;
      cas_code_invalid_out        <= 1'b0;
      added_command_latency_out   <= '0;
      total_read_latency_out      <= '0;
    end else if (clk_en_in) begin
      recovery_reserved_out       <= recov_code > RECOV_MAX_CODE;
      write_recovery_count_out    <= recov_decode(recov_code);
      read_to_precharge_count_out <= 4'(recov_decode(recov_code) >> 1);
      read_cas_delay_out          <= cas_val;
      // stacked-only codes invalid on single die
      cas_code_invalid_out <= (cas_code > CAS_MAX_CODE) ||
                              (!STACKED_DIE && (cas_code == CAS_STACK_A ||
                                                cas_code == CAS_STACK_B));
      case (add_code)
        ADD_MINUS1: added_command_latency_out <= 6'(cas_val - 6'd1);
        ADD_MINUS2: added_command_latency_out <= 6'(cas_val - 6'd2);
        default:    added_command_latency_out <= 6'h0;
      endcase
      case (add_code)
        ADD_MINUS1: total_read_latency_out <= 7'({cas_val, 1'b0} - 7'd1);
        ADD_MINUS2: total_read_latency_out <= 7'({cas_val, 1'b0} - 7'd2);
        default:    total_read_latency_out <= 7'(cas_val);
      endcase
    end
  end

  // ----------------------------------------
  // Mode flags
  // ----------------------------------------
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      vendor_test_mode_out          <= 1'b0;
      burst_size_out                <= SIZE_FIXED8;
      burst_order_type_out          <= 1'b0;
      output_disable_out            <= 1'b0;
      extra_termination_strobe_out  <= 1'b0;
      nominal_termination_out       <= 3'h0;
      nominal_termination_div_out   <= 3'h0;
      write_leveling_mode_out       <= 1'b0;
      driver_impedance_out          <= 1'b0;
      driver_impedance_reserved_out <= 1'b0;
    end else if (clk_en_in) begin
      vendor_test_mode_out <= burst_latency_mode_reg_r[TEST_BIT_POS];
      burst_size_out       <= burst_latency_mode_reg_r[1:0];
      burst_order_type_out <= burst_latency_mode_reg_r[ORDER_TYPE_POS];
      output_disable_out   <= output_termination_mode_reg_r[OUT_DIS_POS];
      // strobe termination only on byte-wide part
      extra_termination_strobe_out <= BYTE_WIDE_PART &&
                                      output_termination_mode_reg_r[XTERM_POS];
      nominal_termination_out <= output_termination_mode_reg_r[10:8];
      case (output_termination_mode_reg_r[10:8])
        3'h1:    nominal_termination_div_out <= 3'h4;
        3'h2:    nominal_termination_div_out <= 3'h2;
        3'h3:    nominal_termination_div_out <= 3'h6;
        3'h4:    nominal_termination_div_out <= 3'h1;
        3'h5:    nominal_termination_div_out <= 3'h5;
        3'h6:    nominal_termination_div_out <= 3'h3;
        3'h7:    nominal_termination_div_out <= 3'h7;
        default: nominal_termination_div_out <= 3'h0;
      endcase
      write_leveling_mode_out <= output_termination_mode_reg_r[LEVEL_POS];
      // driver impedance, 0 for over seven, 1 for over five
      driver_impedance_out          <= output_termination_mode_reg_r[1];
      driver_impedance_reserved_out <= output_termination_mode_reg_r[2];
    end
  end

  // ----------------------------------------
  // Column command burst control
  // ----------------------------------------
  logic [23:0] order_c;
  logic [7:0]  drive_c;
  // per-command chop from burst chop pin (low selects chop)
  always_comb begin
    case (burst_size_out)
      SIZE_PER_CMD: chop_sel = !addr_in[12];
      SIZE_FIXED4:  chop_sel = 1'b1;
      default:      chop_sel = 1'b0;
    endcase
  end
  burst_order_gen u_order (
    .start_col_in   (addr_in[2:0]),
    .interleave_in  (burst_order_type_out),
    .is_write_in    (is_write),
    .chop_in        (chop_sel),
    .order_out      (order_c),
    .beat_drive_out (drive_c)
  );
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      col_cmd_out           <= 1'b0;
      four_beat_chop_out    <= 1'b0;
      beat_order_out        <= '0;
      beat_drive_out        <= 8'h0;
      early_write_start_out <= 1'b0;
      write_commit_out      <= 1'b0;
      write_abort_out       <= 1'b0;
    end else if (clk_en_in) begin
      col_cmd_out <= is_col;
      if (is_col) begin
        four_beat_chop_out <= chop_sel;
        beat_order_out     <= order_c;
        // read drive mask; writes drive nothing
        beat_drive_out     <= is_write ? 8'h0 : drive_c;
      end
      // early internal write only with fixed chop
      early_write_start_out <= is_col && is_write && burst_size_out == SIZE_FIXED4;
      // checksum mismatch aborts write when masking and checksum on
      write_commit_out <= is_col && is_write &&
                          !(mask_enable_in && crc_enable_in && !crc_ok_in);
      write_abort_out  <= is_col && is_write && mask_enable_in && crc_enable_in &&
                          !crc_ok_in;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence mrs_to_first;
    clk_en_in && is_mrs && sel == SEL_BURST_LAT;
  endsequence
  chk_mr_capture: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    mrs_to_first |=> burst_latency_mode_reg_r == $past(mrs_word))
    else $error("first mode register not captured");
  chk_unused_sel: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && is_mrs && sel == SEL_DO_NOT_USE |=> $stable(burst_latency_mode_reg_r) &&
    $stable(output_termination_mode_reg_r))
    else $error("unused select code changed a register");
  chk_reg_hold: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    !is_mrs |=> $stable(output_termination_mode_reg_r))
    else $error("register changed without mode write");
  chk_dll_clear: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && !is_mrs && dll_reset_done_in |=> !dll_reset_req_out)
    else $error("dll reset did not self clear");
  chk_fixed_chop: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && is_col && is_write && burst_size_out == SIZE_FIXED8 |=> !early_write_start_out)
    else $error("early write start without fixed chop");
  chk_chop_tail: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && is_col && !is_write && burst_size_out == SIZE_FIXED4 |=>
    beat_drive_out == 8'h0F)
    else $error("chopped read tail driven");
  chk_crc_abort: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    clk_en_in && is_col && is_write && mask_enable_in && crc_enable_in && !crc_ok_in |=>
    write_abort_out && !write_commit_out)
    else $error("bad checksum write committed");
  chk_latency_sum: assert property (@(posedge clk_in) disable iff (!rst_n_in)
    total_read_latency_out == 7'(added_command_latency_out) + 7'(read_cas_delay_out))
    else $error("total latency not sum");
endmodule

// ==== mem_ctrl_model.sv ====
// Controller model issuing mode and column commands
`timescale 1ns/100ps
module mem_ctrl_model #(
  parameter int MODE_GAP = 8
)
(
  input  wire logic        clk_in,
  output logic             cs_n_out,
  output logic             ras_n_out,
  output logic             cas_n_out,
  output logic             we_n_out,
  output logic [1:0]       bank_group_out,
  output logic [1:0]       bank_out,
  output logic [17:0]      addr_out
);
  initial begin
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hF;
    bank_group_out = 2'h0;
    bank_out       = 2'h0;
    addr_out       = 18'h00000;
  end
  // Deselect; address lines toggle so no stale value survives
  task automatic idle();
    @(posedge clk_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'hF;
    bank_group_out <= ~bank_group_out;
    bank_out       <= ~bank_out;
    addr_out       <= ~addr_out;
  endtask
  // Full word, strobes low, reserved zero
  task automatic mrs(input logic [2:0] sel, input logic [13:0] word);
    @(posedge clk_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'h0;
    bank_group_out <= {1'b0, sel[2]};
    bank_out       <= sel[1:0];
    addr_out       <= {4'h0, word};
    repeat (MODE_GAP) idle();
    #1;
  endtask
  // Burst chop pin sampled with column command
  task automatic col(input logic wr, input logic chop_n, input logic [2:0] s);
    @(posedge clk_in);
    {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= {3'b010, ~wr};
    bank_group_out <= 2'h0;
    bank_out       <= 2'h0;
    addr_out       <= {5'h00, chop_n, 9'h000, s};
    idle();
    #1;
  endtask
endmodule

// ==== sdram_mode_reg_decode_tb.sv ====
// Self-checking testbench for the mode register decode block
`timescale 1ns/100ps
module sdram_mode_reg_decode_tb;
  import mode_reg_pkg::*;
  logic clk_in, rst_n_in, clk_en_in, cs_n_in, ras_n_in, cas_n_in, we_n_in;
  logic dll_reset_done_in, mask_enable_in, crc_enable_in, crc_ok_in;
  logic [1:0]  bank_group_in, bank_in, burst_size_out;
  logic [17:0] addr_in;
  logic [4:0]  write_recovery_count_out;
  logic [3:0]  read_to_precharge_count_out;
  logic [5:0]  read_cas_delay_out, added_command_latency_out;
  logic [6:0]  total_read_latency_out;
  logic [2:0]  nominal_termination_out, nominal_termination_div_out;
  logic [23:0] beat_order_out;
  logic [7:0]  beat_drive_out;
  logic recovery_reserved_out, dll_reset_req_out, vendor_test_mode_out, cas_code_invalid_out;
  logic burst_order_type_out, output_disable_out, extra_termination_strobe_out;
  logic write_leveling_mode_out, driver_impedance_out, driver_impedance_reserved_out;
  logic col_cmd_out, four_beat_chop_out, early_write_start_out, write_commit_out;
  logic write_abort_out;
  int   checked, err_total, cur_cl, cur_al;
  int   cas_tab[24] = '{9, 10, 11, 12, 13, 14, 15, 16, 18, 20, 22, 24, 23, 17, 19, 21,
                        25, 26, 27, 28, 29, 30, 31, 32};
  int   div_tab[8] = '{0, 4, 2, 6, 1, 5, 3, 7};

  sdram_mode_reg_decode u_sdram_mode_reg_decode (.*);
  mem_ctrl_model u_mem_ctrl_model (
    .clk_in         (clk_in),
    .cs_n_out       (cs_n_in),
    .ras_n_out      (ras_n_in),
    .cas_n_out      (cas_n_in),
    .we_n_out       (we_n_in),
    .bank_group_out (bank_group_in),
    .bank_out       (bank_in),
    .addr_out       (addr_in)
  );

  initial begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [23:0] ord(input logic [2:0] s, input logic bt);
    logic [23:0] o;
    logic [2:0]  b;
    for (int i = 0; i < 8; i++) begin
      b = 3'(i);
      o[3*i+:3] = bt ? (s ^ b) : {s[2] ^ b[2], s[1:0] + b[1:0]};
    end
    return o;
  endfunction

  task automatic t_mr1(input int n);
    logic [1:0] al;
    int         add;
    al  = 2'(n % 3);
    add = (al == 2'h0) ? 0 : cur_cl - int'(al);
    cur_al = int'(al);
    u_mem_ctrl_model.mrs(SEL_OUT_TERM, {1'b0, n == 5, n[1], n[2:0], n[2], 2'h0, al, 1'b0, n[0], 1'b1});
    chk(nominal_termination_out, n[2:0]);
    if (n != 0) chk(nominal_termination_div_out, div_tab[n]);
    chk(output_disable_out, n == 5);
    chk(extra_termination_strobe_out, n[1]);
    chk(write_leveling_mode_out, n[2]);
    chk(driver_impedance_out, n[0]);
    chk(added_command_latency_out, add);
    chk(total_read_latency_out, add + cur_cl);
    $display("test mode word 1 done");
  endtask

  task automatic t_mr0();
    logic [3:0] r;
    logic [4:0] c;
    for (int i = 0; i < 25; i++) begin
      r = (i == 24) ? 4'h9 : 4'(i % 9);
      c = 5'(i % 24);
      u_mem_ctrl_model.mrs(SEL_BURST_LAT, {r[3], c[4], r[2:0], 2'h0, c[3:1], i[0], c[0], 2'(i % 3)});
      cur_cl = cas_tab[c];
      chk(recovery_reserved_out, i == 24);
      if (i < 24) chk(write_recovery_count_out, r == 6 ? 24 : r == 7 ? 22 : 10 + 2 * r);
      if (i < 24) chk(read_to_precharge_count_out, r == 6 ? 12 : r == 7 ? 11 : 5 + r);
      chk(read_cas_delay_out, cur_cl);
      chk(cas_code_invalid_out, c == CAS_STACK_A || c == CAS_STACK_B);
      chk(burst_size_out, i % 3);
      chk(burst_order_type_out, i[0]);
      chk(vendor_test_mode_out, 1'b0);
      chk(added_command_latency_out, cur_al == 0 ? 0 : cur_cl - cur_al);
      chk(total_read_latency_out, cur_cl + (cur_al == 0 ? 0 : cur_cl - cur_al));
    end
    $display("test mode word 0 done");
  endtask

  task automatic t_refuse();
    u_mem_ctrl_model.mrs(SEL_DO_NOT_USE, 14'h3FFF);
    u_mem_ctrl_model.mrs(3'h2, 14'h3FFF);
    @(posedge clk_in) clk_en_in <= 1'b0;
    u_mem_ctrl_model.mrs(SEL_BURST_LAT, 14'h0000);
    @(posedge clk_in) clk_en_in <= 1'b1;
    #1;
    chk(read_cas_delay_out, cur_cl);
    chk(output_disable_out, 1'b0);
    chk(recovery_reserved_out, 1'b1);
    chk(nominal_termination_out, 3'h7);
    chk(driver_impedance_reserved_out, 1'b0);
    $display("test refused writes done");
  endtask

  task automatic t_dll();
    u_mem_ctrl_model.mrs(SEL_BURST_LAT, 14'h0100);
    cur_cl = 9;
    chk(dll_reset_req_out, 1'b1);
    @(posedge clk_in) dll_reset_done_in <= 1'b1;
    @(posedge clk_in) dll_reset_done_in <= 1'b0;
    @(posedge clk_in) #1;
    chk(dll_reset_req_out, 1'b0);
    chk(read_cas_delay_out, 9);
    $display("test dll reset done");
  endtask

  task automatic t_read();
    for (int k = 0; k < 16; k++) begin
      u_mem_ctrl_model.mrs(SEL_BURST_LAT, {10'h000, k[3], 1'b0, SIZE_PER_CMD});
      u_mem_ctrl_model.col(1'b0, 1'b1, k[2:0]);
      chk(col_cmd_out, 1'b1);
      chk(beat_order_out, ord(k[2:0], k[3]));
      chk(beat_drive_out, 8'hFF);
      chk(four_beat_chop_out, 1'b0);
      u_mem_ctrl_model.col(1'b0, 1'b0, k[2:0]);
      chk(four_beat_chop_out, 1'b1);
      chk(beat_order_out[11:0], ord(k[2:0], k[3]) & 24'h000FFF);
      chk(beat_drive_out, 8'h0F);
    end
    $display("test read order done");
  endtask

  task automatic t_write();
    logic [1:0] sz;
    @(posedge clk_in) {mask_enable_in, crc_enable_in} <= 2'h3;
    for (int k = 0; k < 3; k++) begin
      sz = 2'(k);
      @(posedge clk_in) crc_ok_in <= (k != 1);
      u_mem_ctrl_model.mrs(SEL_BURST_LAT, {12'h000, sz});
      u_mem_ctrl_model.col(1'b1, 1'b0, 3'h5);
      chk(early_write_start_out, sz == SIZE_FIXED4);
      chk(four_beat_chop_out, sz != SIZE_FIXED8);
      chk(beat_order_out[11:0], sz == SIZE_FIXED8 ? 12'h688 : 12'hFAC);
      chk(beat_drive_out, 8'h00);
      chk(write_abort_out, k == 1);
      chk(write_commit_out, k != 1);
      if (sz == SIZE_FIXED4) begin
        u_mem_ctrl_model.col(1'b0, 1'b1, 3'h5);
        chk(four_beat_chop_out, 1'b1);
        chk(beat_order_out[11:0], ord(3'h5, 1'b0) & 24'h000FFF);
        chk(beat_drive_out, 8'h0F);
      end
    end
    $display("test write chop done");
  endtask

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    {rst_n_in, dll_reset_done_in, mask_enable_in, crc_enable_in, crc_ok_in} = 5'h00;
    clk_en_in = 1'b1;
    checked   = 0;
    err_total = 0;
    cur_cl    = 9;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int n = 0; n < 8; n++) t_mr1(n);
    t_mr0();
    t_mr1(7);
    t_refuse();
    t_dll();
    t_read();
    t_write();
    conclude();
  end

  initial begin
    #100us;
    err_total++;
    conclude();
  end
endmodule
